// >>> rtl/wakeup_filter_port_pkg.sv
// Constants and carrier types for the wake-up filter store.
// Assumes an AHB-Lite fabric and a MAC receive path on one clock.
package filter_store_pkg;

    // Store geometry
    localparam int NUM_FILTERS = 8;
    localparam int STORE_WORDS = 40;
    localparam int MASK_WORDS_PER_FILTER = 4;
    localparam int MASK_BITS = 128;
    localparam int INDEX_W = 6;

    // Word layout inside the store
    localparam logic [INDEX_W-1:0] MASK_BASE = 6'h00;
    localparam logic [INDEX_W-1:0] CMD_BASE = 6'h20;
    localparam logic [INDEX_W-1:0] OFS_BASE = 6'h22;
    localparam logic [INDEX_W-1:0] CRC_BASE = 6'h24;
    localparam logic [INDEX_W-1:0] LAST_INDEX = 6'h27;
    localparam logic [INDEX_W-1:0] INDEX_RST = 6'h00;

    // Field positions
    localparam int CMD_LANE_W = 8;
    localparam int CMD_W = 4;
    localparam int OFS_W = 8;
    localparam int CRC_W = 16;
    localparam int CMD_EN_BIT = 0;
    localparam int CMD_TYPE_LSB = 2;
    localparam logic [31:0] CMD_WORD_MASK = 32'h0F0F0F0F;

    // Reset values
    localparam logic [31:0] WORD_RST = 32'h00000000;
    localparam logic [15:0] CRC_PRESET = 16'hFFFF;

    // Frame byte position counter
    localparam int POS_W = 9;
    localparam logic [POS_W-1:0] POS_MAX = 9'h1FF;

    // Bus map (byte addresses)
    localparam logic [7:0] PORT_ADDR = 8'h00;
    localparam logic [7:0] INDEX_ADDR = 8'h04;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [1:0] {
        ADDR_UNICAST = 2'h0,
        ADDR_ANY = 2'h1,
        ADDR_MULTICAST = 2'h2
    } addr_type_t;

    // One received byte from the MAC
    typedef struct packed {
        logic sof;
        logic valid;
        logic [7:0] data;
    } rx_byte_t;

    // Per-filter view handed to the match logic
    typedef struct packed {
        logic enable;
        addr_type_t addr_type;
        logic [OFS_W-1:0] offset;
        logic [CRC_W-1:0] expected_crc;
    } filter_cfg_t;

endpackage

// >>> rtl/filter_word_mem.sv
// Word store with registered read port and a full parallel view.
// Assumes one writer and one reader on the same clock.
`timescale 1ns/1ns
module filter_word_mem
    import filter_store_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = STORE_WORDS,
    parameter int AW = INDEX_W
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Write port
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [WIDTH-1:0] i_wdata,
    // Read port
    input wire logic [AW-1:0] i_raddr,
    output logic [WIDTH-1:0] o_rdata,
    // Parallel view
    output logic [DEPTH-1:0][WIDTH-1:0] o_words
);

    if (DEPTH > (1 << AW) || DEPTH < 1) begin : g_bad_depth
        $error("filter_word_mem: depth does not fit address");
    end

    logic [DEPTH-1:0][WIDTH-1:0] words;

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_word
            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    words[g] <= WIDTH'(WORD_RST);
                end else if (i_we && i_waddr == AW'(g)) begin
                    words[g] <= i_wdata;
                end
            end
        end
    endgenerate

    wire raddr_ok = i_raddr < AW'(DEPTH);

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= raddr_ok ? words[i_raddr] : '0;
        end
    end

    assign o_words = words;

endmodule

// >>> rtl/wakeup_filter_store.sv
// Wake-up frame filter store with indexed port and CRC-16 engines.
// Assumes an AHB-Lite master and MAC receive bytes on i_clk.
//
// What this block does
// - The store opens with 32 mask words, four per filter, filter 0 first.
// - Mask words 0..3 give mask bits 31:0..127:96, lsb earliest byte.
// - A set mask bit j feeds byte offset+j to the CRC, a clear bit skips.
// - Offsets pack four per word, filter 0 in lane 0, filters 4..7 next.
// - After reset the index is at word 0 and each port access moves it on.
// - Command bit 0 enables a filter and bits 3:2 pick the address type.
// - The CRC presets to all ones per frame and updates on chosen bytes.
`timescale 1ns/1ns
module wakeup_filter_store
    import filter_store_pkg::*;
#(
    parameter int FILTERS = NUM_FILTERS
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // AHB-Lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // Receive byte stream
    input wire rx_byte_t i_rx,
    // Filter view for the match logic
    output filter_cfg_t [FILTERS-1:0] o_cfg,
    output logic [FILTERS-1:0][CRC_W-1:0] o_crc,
    output logic [INDEX_W-1:0] o_index
);

    if (FILTERS != NUM_FILTERS) begin : g_bad_filters
        $error("wakeup_filter_store: layout serves eight filters");
    end

    function automatic logic [INDEX_W-1:0] next_index_of(
        input logic [INDEX_W-1:0] idx
    );
        next_index_of = (idx >= LAST_INDEX) ? INDEX_RST : idx + 6'h01;
    endfunction

    function automatic logic [31:0] write_mask_of(
        input logic [INDEX_W-1:0] idx
    );
        write_mask_of = (idx >= CMD_BASE && idx < OFS_BASE) ?
            CMD_WORD_MASK : 32'hFFFFFFFF;
    endfunction

    function automatic addr_type_t addr_type_of(input logic [1:0] bits);
        if (bits[0]) begin
            addr_type_of = ADDR_ANY;
        end else if (bits[1]) begin
            addr_type_of = ADDR_MULTICAST;
        end else begin
            addr_type_of = ADDR_UNICAST;
        end
    endfunction

    function automatic logic [15:0] crc16_byte(
        input logic [15:0] c,
        input logic [7:0] d
    );
        logic [7:0] f;
        logic [15:0] n;
        f[0] = c[15] ^ d[0];
        f[1] = c[14] ^ f[0] ^ d[1];
        f[2] = c[13] ^ f[1] ^ d[2];
        f[3] = c[12] ^ f[2] ^ d[3];
        f[4] = c[11] ^ f[3] ^ d[4];
        f[5] = c[10] ^ f[4] ^ d[5];
        f[6] = c[9] ^ f[5] ^ d[6];
        f[7] = c[8] ^ f[6] ^ d[7];
        n[15] = c[7] ^ f[7];
        n[14:10] = c[6:2];
        n[9] = c[1] ^ f[0];
        n[8] = c[0] ^ f[1];
        n[7] = f[0] ^ f[2];
        n[6] = f[1] ^ f[3];
        n[5] = f[2] ^ f[4];
        n[4] = f[3] ^ f[5];
        n[3] = f[4] ^ f[6];
        n[2] = f[5] ^ f[7];
        n[1] = f[6];
        n[0] = f[7];
        crc16_byte = n;
    endfunction

    // Address phase decode
    wire addr_valid = i_hsel && i_hready &&
        (i_htrans == HTRANS_NONSEQ || i_htrans == HTRANS_SEQ);
    wire addr_word = i_hsize == HSIZE_WORD;
    wire hit_port = addr_valid && addr_word && i_haddr[7:0] == PORT_ADDR &&
        i_haddr[31:8] == 24'h000000;
    wire hit_index = addr_valid && addr_word &&
        i_haddr[7:0] == INDEX_ADDR && i_haddr[31:8] == 24'h000000;

    // Data phase flags
    logic dp_wr_port;
    logic dp_rd_port;
    logic dp_wr_index;
    logic dp_rd_index;
    logic [INDEX_W-1:0] index;
    logic [INDEX_W-1:0] rd_index_snap;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            dp_wr_port <= 1'b0;
            dp_rd_port <= 1'b0;
            dp_wr_index <= 1'b0;
            dp_rd_index <= 1'b0;
        end else if (i_hready) begin
            dp_wr_port <= hit_port && i_hwrite;
            dp_rd_port <= hit_port && !i_hwrite;
            dp_wr_index <= hit_index && i_hwrite;
            dp_rd_index <= hit_index && !i_hwrite;
        end
    end

    // Index pointer: reset to word 0, advance on each port access
    wire port_step = dp_wr_port || dp_rd_port;
    wire [INDEX_W-1:0] index_load = (i_hwdata[INDEX_W-1:0] > LAST_INDEX ||
        i_hwdata[31:INDEX_W] != 26'h0000000) ?
        INDEX_RST : i_hwdata[INDEX_W-1:0];
    wire [INDEX_W-1:0] next_index = port_step ? next_index_of(index) :
        dp_wr_index ? index_load : index;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            index <= INDEX_RST;
        end else begin
            index <= next_index;
        end
    end

    // A read issued while the previous access still steps uses the new word
    wire [INDEX_W-1:0] read_addr = port_step ? next_index_of(index) :
        dp_wr_index ? index_load : index;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rd_index_snap <= INDEX_RST;
        end else if (hit_index && !i_hwrite) begin
            rd_index_snap <= read_addr;
        end
    end

    // Store writes, reserved command bits held at zero
    wire [31:0] store_wdata = i_hwdata & write_mask_of(index);
    wire [31:0] store_rdata;
    logic [STORE_WORDS-1:0][31:0] words;

    filter_word_mem #(
        .WIDTH(32),
        .DEPTH(STORE_WORDS),
        .AW(INDEX_W)
    ) u_mem (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_we(dp_wr_port),
        .i_waddr(index),
        .i_wdata(store_wdata),
        .i_raddr(read_addr),
        .o_rdata(store_rdata),
        .o_words(words)
    );

    // Read data and response
    assign o_hrdata = dp_rd_port ? store_rdata :
        dp_rd_index ? {26'h0000000, rd_index_snap} : 32'h00000000;
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_index = index;

    // Frame byte position
    logic [POS_W-1:0] pos_count;
    wire [POS_W-1:0] cur_pos = i_rx.sof ? '0 : pos_count;
    wire [POS_W-1:0] next_pos = (cur_pos == POS_MAX) ? POS_MAX :
        cur_pos + 9'h001;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            pos_count <= '0;
        end else if (i_rx.valid) begin
            pos_count <= next_pos;
        end
    end

    // Per-filter field extraction and CRC engines
    genvar f;
    generate
        for (f = 0; f < FILTERS; f++) begin : g_filter
            localparam int MW = int'(MASK_BASE) + MASK_WORDS_PER_FILTER * f;
            localparam int CW = int'(CMD_BASE) + f / 4;
            localparam int OW = int'(OFS_BASE) + f / 4;
            localparam int RW = int'(CRC_BASE) + f / 2;

            wire [MASK_BITS-1:0] mask = {words[MW+3], words[MW+2],
                words[MW+1], words[MW]};
            wire [CMD_W-1:0] cmd =
                words[CW][CMD_LANE_W*(f%4) +: CMD_W];
            wire [OFS_W-1:0] ofs =
                words[OW][OFS_W*(f%4) +: OFS_W];
            wire [CRC_W-1:0] exp_crc =
                words[RW][CRC_W*(f%2) +: CRC_W];

            wire [POS_W-1:0] ofs_wide = {1'b0, ofs};
            wire [POS_W-1:0] rel = cur_pos - ofs_wide;
            wire in_window = cur_pos >= ofs_wide &&
                rel < POS_W'(MASK_BITS);
            wire take = i_rx.valid && in_window &&
                mask[rel[6:0]];

            logic [CRC_W-1:0] crc;
            wire [CRC_W-1:0] base_crc = i_rx.sof ? CRC_PRESET : crc;
            wire [CRC_W-1:0] next_crc = take ?
                crc16_byte(base_crc, i_rx.data) : base_crc;

            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    crc <= CRC_PRESET;
                end else if (i_rx.valid) begin
                    crc <= next_crc;
                end
            end

            assign o_crc[f] = crc;
            assign o_cfg[f].enable = cmd[CMD_EN_BIT];
            assign o_cfg[f].addr_type =
                addr_type_of(cmd[CMD_TYPE_LSB +: 2]);
            assign o_cfg[f].offset = ofs;
            assign o_cfg[f].expected_crc = exp_crc;
        end
    endgenerate

endmodule

// >>> dv/wakeup_filter_port_monitor.sv
// Port checker for the wake-up filter store.
// Bound to every store instance; single clock domain.
`timescale 1ns/1ns
module filter_store_monitor
    import filter_store_pkg::*;
#(
    parameter int FILTERS = NUM_FILTERS
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Bus
    input wire logic i_hsel,
    input wire logic i_hwrite,
    input wire logic i_hready,
    input wire logic [31:0] i_haddr,
    input wire logic [31:0] i_hwdata,
    input wire logic [31:0] o_hrdata,
    input wire logic [1:0] i_htrans,
    input wire logic [2:0] i_hsize,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    // Receive stream and filter view
    input wire rx_byte_t i_rx,
    input wire filter_cfg_t [FILTERS-1:0] o_cfg,
    input wire logic [FILTERS-1:0][CRC_W-1:0] o_crc,
    input wire logic [INDEX_W-1:0] o_index
);
    wire logic acc = i_hsel && i_hready && i_htrans[1]
        && i_hsize == HSIZE_WORD && i_haddr[31:8] == 24'h000000;
    wire logic port_acc = acc && i_haddr[7:0] == PORT_ADDR;
    wire logic idx_wr = acc && i_hwrite && i_haddr[7:0] == INDEX_ADDR;
    wire logic rd_acc = acc && !i_hwrite;
    wire logic wr_acc = acc && i_hwrite;
    wire logic [5:0] wd_idx = i_hwdata[5:0];
    wire logic wd_big = i_hwdata > 32'h00000027;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    bus_okay_a: assert property (o_hreadyout && !o_hresp)
        else $error("bus answer not ready and okay");
    index_reset_a: assert property (disable iff (1'b0)
        !i_rst_n |=> o_index == INDEX_RST) else $error("index not cleared");
    index_step_a: assert property (port_acc |=> ##1 o_index ==
        ($past(o_index) == LAST_INDEX ? INDEX_RST : $past(o_index) + 6'h01))
        else $error("index did not step");
    index_load_a: assert property (idx_wr |=> ##1 o_index ==
        ($past(wd_big) ? INDEX_RST : $past(wd_idx)))
        else $error("index not loaded");
    rd_idle_a: assert property (!$past(rd_acc) |-> o_hrdata == 32'h0)
        else $error("read data outside data phase");
    crc_preset_a: assert property (i_rx.valid && i_rx.sof
        && o_cfg[0].offset != 8'h00 |=> o_crc[0] == CRC_PRESET)
        else $error("crc not preset at frame start");
    crc_hold_a: assert property (!i_rx.valid |=> $stable(o_crc))
        else $error("crc moved without a byte");
    cfg_stable_a: assert property ($past(i_rst_n)
        && !$past(wr_acc, 2) |-> $stable(o_cfg))
        else $error("filter view changed without a write");
endmodule

bind wakeup_filter_store filter_store_monitor #(
    .FILTERS(FILTERS)
) u_filter_store_monitor (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel), .i_hwrite(i_hwrite),
    .i_hready(i_hready), .i_haddr(i_haddr), .i_hwdata(i_hwdata),
    .o_hrdata(o_hrdata), .i_htrans(i_htrans), .i_hsize(i_hsize),
    .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_rx(i_rx),
    .o_cfg(o_cfg), .o_crc(o_crc), .o_index(o_index));

// >>> dv/tb.sv
// Self-checking bench for the wake-up filter store.
// Drives the AHB-Lite port and receive stream directly.
`timescale 1ns/1ns
module tb
    import filter_store_pkg::*;
;
    logic i_clk = 1'b0, i_rst_n = 1'b0, i_hsel = 1'b0, i_hwrite = 1'b0;
    logic [31:0] i_haddr = '0, i_hwdata = '0, o_hrdata, rd;
    logic [31:0] mem [0:39];
    logic [1:0] i_htrans = '0;
    logic [2:0] i_hsize = '0;
    rx_byte_t i_rx = '0;
    logic [2:0] bus_size = HSIZE_WORD;
    logic o_hreadyout, o_hresp;
    filter_cfg_t [7:0] o_cfg;
    logic [7:0][15:0] o_crc, crc;
    logic [5:0] o_index;
    int n_fail = 0, checks_done = 0, idx = 0, cyc = 0, seed = 32'h6270;
    wakeup_filter_store #(.FILTERS(8)) u_wakeup_filter_store (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel), .i_haddr(i_haddr),
        .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize),
        .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hrdata(o_hrdata),
        .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_rx(i_rx),
        .o_cfg(o_cfg), .o_crc(o_crc), .o_index(o_index));
    initial forever #5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        if (n_fail == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        i_hsel <= 1'b1;
        i_haddr <= {24'h000000, a};
        i_htrans <= HTRANS_NONSEQ;
        i_hwrite <= wr;
        i_hsize <= bus_size;
        do @(posedge i_clk); while (o_hreadyout !== 1'b1);
        i_hsel <= 1'b0;
        i_htrans <= 2'h0;
        i_hwdata <= wd;
        do @(posedge i_clk); while (o_hreadyout !== 1'b1);
        rd = o_hrdata;
    endtask
    task automatic port(input logic wr, input logic [31:0] d);
        bus(wr, PORT_ADDR, d);
        if (wr) begin
            mem[idx] = (idx inside {32, 33}) ? d & CMD_WORD_MASK : d;
        end else begin
            chk(rd, mem[idx]);
        end
        idx = (idx == 39) ? 0 : idx + 1;
    endtask
    task automatic chk_reset();
        chk(o_index, 32'h0);
        for (int f = 0; f < 8; f++) begin
            chk(o_crc[f], CRC_PRESET);
            chk(o_cfg[f], 32'h0);
        end
        idx = 0;
        foreach (mem[k]) mem[k] = '0;
    endtask
    function automatic logic [31:0] wval(input int k);
        return k == 32 ? 32'hFEF9F6F1 : k == 34 ? 32'h0D010003 :
               k == 35 ? 32'h80201005 : $random(seed);
    endfunction
    function automatic addr_type_t atype(input logic [3:0] c);
        return c[2] ? ADDR_ANY : c[3] ? ADDR_MULTICAST : ADDR_UNICAST;
    endfunction
    function automatic logic [15:0] crc16(input logic [15:0] c,
                                          input logic [7:0] d);
        logic [7:0] f;
        f[0] = c[15] ^ d[0];
        for (int i = 1; i < 8; i++) f[i] = c[15 - i] ^ f[i - 1] ^ d[i];
        return {c[7] ^ f[7], c[6:2], c[1] ^ f[0], c[0] ^ f[1], f[0] ^ f[2],
                f[1] ^ f[3], f[2] ^ f[4], f[3] ^ f[5], f[4] ^ f[6],
                f[5] ^ f[7], f[6], f[7]};
    endfunction
    task automatic frame(input int len);
        int p, o;
        logic [7:0] b;
        for (int f = 0; f < 8; f++) crc[f] = CRC_PRESET;
        p = 0;
        while (p < len) begin
            b = $random(seed);
            if (($random(seed) & 3) == 0) begin
                i_rx <= {2'b00, b};
            end else begin
                i_rx <= {p == 0, 1'b1, b};
                for (int f = 0; f < 8; f++) begin
                    o = p - int'(mem[34 + f / 4][8 * (f % 4) +: 8]);
                    if (o >= 0 && o < 128 && mem[4 * f + o / 32][o % 32])
                        crc[f] = crc16(crc[f], b);
                end
                p++;
            end
            @(posedge i_clk);
        end
        i_rx <= '0;
        @(posedge i_clk);
        for (int f = 0; f < 8; f++) chk(o_crc[f], crc[f]);
    endtask
    initial begin
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        chk_reset();
        repeat (40) port(1'b0, 32'h0);
        for (int k = 0; k < 40; k++) port(1'b1, wval(k));
        @(posedge i_clk);
        chk(o_index, 32'h0);
        for (int f = 0; f < 8; f++) begin
            rd = mem[32 + f / 4] >> (8 * (f % 4));
            chk(o_cfg[f].enable, rd[0]);
            chk(o_cfg[f].addr_type, atype(rd[3:0]));
            rd = mem[34 + f / 4] >> (8 * (f % 4));
            chk(o_cfg[f].offset, rd[7:0]);
            rd = mem[36 + f / 2] >> (16 * (f % 2));
            chk(o_cfg[f].expected_crc, rd[15:0]);
        end
        repeat (40) port(1'b0, $random(seed));
        frame(300);
        frame(200);
        port(1'b0, 32'h0);
        bus(1'b1, INDEX_ADDR, 32'h0000002D);
        bus(1'b0, INDEX_ADDR, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, INDEX_ADDR, 32'h00000024);
        bus(1'b0, INDEX_ADDR, 32'h0);
        chk(rd, 32'h00000024);
        idx = 36;
        port(1'b0, 32'h0);
        bus(1'b1, 8'h08, $random(seed));
        bus(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0);
        bus_size = 3'h1;
        bus(1'b1, PORT_ADDR, $random(seed));
        bus_size = HSIZE_WORD;
        port(1'b0, 32'h0);
        i_rst_n <= 1'b0;
        @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        chk_reset();
        port(1'b0, 32'h0);
        print_verdict();
    end
endmodule
